// ### logic/arct_defs.vh
`ifndef ARCT_DEFS_VH
`define ARCT_DEFS_VH
// Register byte addresses
`define ARCT_ADDR_CTRL      8'h00
`define ARCT_ADDR_CAPSRC    8'h04
`define ARCT_ADDR_CNT_LO    8'h08
`define ARCT_ADDR_CNT_HI    8'h0C
`define ARCT_ADDR_RCAP_LO   8'h10
`define ARCT_ADDR_RCAP_HI   8'h14
`define ARCT_ADDR_IRQ_STAT  8'h18
`define ARCT_ADDR_IRQ_MASK  8'h1C
`define ARCT_ADDR_IEN       8'h20
// Control field positions
`define ARCT_BIT_OVF        7
`define ARCT_BIT_EXF        6
`define ARCT_PS_HI          5
`define ARCT_PS_LO          4
`define ARCT_MODE_HI        3
`define ARCT_MODE_LO        2
`define ARCT_BIT_RUN        1
`define ARCT_BIT_EXEN       0
// Mode codes
`define ARCT_MODE_RELOAD    2'b00
`define ARCT_MODE_BAUD      2'b01
`define ARCT_MODE_CAP_RISE  2'b10
`define ARCT_MODE_CAP_FALL  2'b11
// Prescaler terminal counts
`define ARCT_PS_DIV1        8'h00
`define ARCT_PS_DIV8        8'h07
`define ARCT_PS_DIV64       8'h3F
`define ARCT_PS_DIV256      8'hFF
`define ARCT_BAUD_OVS       4'hF
// Reset values and counter top
`define ARCT_RST_BYTE       8'h00
`define ARCT_CNT_MAX        16'hFFFF
`define ARCT_CNT_ZERO       16'h0000
// AXI responses
`define ARCT_RESP_OKAY      2'b00
`define ARCT_RESP_SLVERR    2'b10
`endif

// ### logic/arct_timer.v
`include "arct_defs.vh"
`default_nettype none
// Contract
// - Reload mode: count up, wrap reloads, sets overflow
// - Reload mode with enable: edge also reloads
// - Interrupt enable passes overflow or event flag
// - Run bit starts/stops, count keeps value
// - Baud mode: overflow reloads, no overflow flag
// - Baud mode edge sets event, no reload
// - Baud tick is overflow divided by sixteen
// - Capture modes free run, wrap to zero
// - Rising capture copies count, sets event
// - Falling capture copies count, sets event
// - Overflow flag bit 7, software zero clears
// - Event flag bit 6, software clears
// - Prescaler divides by 1, 8, 64, 256
// - Mode field selects four modes
// - External enable zero ignores trigger events
// - Capture source selects pin, RC, receives
module arct_timer (
    input  wire        clk_sys,
    input  wire        reset,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        trigger_input_pin,
    input  wire        lf_rc_clock,
    input  wire        uart_one_receive_pin,
    input  wire        uart_two_receive_pin,
    output reg         baud_tick,
    output wire        irq
);

    ////////////////////////////////////////////////////////////////////
    // Registers
    // Configuration and flags
    reg  [7:0]  ctrl_q;
    reg  [1:0]  capsrc_q;

    // Counter core
    reg  [15:0] cnt_q;
    reg  [15:0] rcap_q;

    // Interrupt status, mask and enable
    reg  [1:0]  stat_q;
    reg  [1:0]  mask_q;
    reg         ien_q;

    // Prescaler and baud oversampler
    reg  [7:0]  ps_q;
    reg  [3:0]  ovs_q;

    // Input sampling
    reg  [3:0]  sync1_q;
    reg  [3:0]  sync2_q;
    reg         src_prev_q;

    // Write holding stage
    reg  [7:0]  aw_q;
    reg  [31:0] wd_q;
    reg  [3:0]  ws_q;
    reg         awf_q;
    reg         wf_q;

    // Control fields
    wire [1:0] mode = ctrl_q[`ARCT_MODE_HI:`ARCT_MODE_LO];
    wire       run  = ctrl_q[`ARCT_BIT_RUN];
    wire       exen = ctrl_q[`ARCT_BIT_EXEN];

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers, one per source
    // Sources are plain levels; two flops cut metastability
    wire [3:0] src_raw = {uart_two_receive_pin, uart_one_receive_pin,
                          lf_rc_clock, trigger_input_pin};
    // One flop pair per source through a generate loop
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            // Two-flop synchroniser
            always @(posedge clk_sys) begin
                if (reset) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= src_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // Source select and edge detect
    // Rise and fall come from the second flop only
    wire src_sel  = sync2_q[capsrc_q];
    wire rise     = src_sel & ~src_prev_q;
    wire fall     = ~src_sel & src_prev_q;
    // Reload and baud modes take either edge on the selected source
    wire edge_any = (mode == `ARCT_MODE_CAP_RISE) ? rise :
                    (mode == `ARCT_MODE_CAP_FALL) ? fall :
                    (rise | fall);
    // Enable gates every trigger event
    wire ext_evt  = exen & edge_any;

    // Previous level of the selected source
    // Idle sources are low, so no false edge after reset
    always @(posedge clk_sys) begin
        if (reset)
            src_prev_q <= 1'b0;
        else
            src_prev_q <= src_sel;
    end

    ////////////////////////////////////////////////////////////////////
    // Prescaler
    // Terminal count per ratio code
    reg [7:0] ps_term;
    always @* begin
        case (ctrl_q[`ARCT_PS_HI:`ARCT_PS_LO])
            2'b00:   ps_term = `ARCT_PS_DIV1;
            2'b01:   ps_term = `ARCT_PS_DIV8;
            2'b10:   ps_term = `ARCT_PS_DIV64;
            default: ps_term = `ARCT_PS_DIV256;
        endcase
    end
    // Counting tick and terminal count
    wire tick = run && (ps_q >= ps_term);
    wire wrap = tick && (cnt_q == `ARCT_CNT_MAX);

    // Divider restarts while stopped so each start is clean
    always @(posedge clk_sys) begin
        if (reset || !run || tick)
            ps_q <= 8'h00;
        else
            ps_q <= ps_q + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////
    // Bus write decode
    // Both halves held and no answer pending
    wire       wr_go = awf_q && wf_q && !s_axi_bvalid;
    // Lane 0 carries each register; lane off writes nothing
    wire [7:0] wbyte = ws_q[0] ? wd_q[7:0] : 8'h00;
    wire       wr_en = wr_go && ws_q[0];
    // Unmapped or unaligned target answers with an error
    wire       wr_bad = (aw_q > `ARCT_ADDR_IEN) || (aw_q[1:0] != 2'b00);
    // One strobe per register
    wire wr_ctrl  = wr_en && (aw_q == `ARCT_ADDR_CTRL);
    wire wr_cnt_l = wr_en && (aw_q == `ARCT_ADDR_CNT_LO);
    wire wr_cnt_h = wr_en && (aw_q == `ARCT_ADDR_CNT_HI);
    wire wr_rc_l  = wr_en && (aw_q == `ARCT_ADDR_RCAP_LO);
    wire wr_rc_h  = wr_en && (aw_q == `ARCT_ADDR_RCAP_HI);
    // A status read clears the sticky bits
    wire rd_stat  = s_axi_arvalid && s_axi_arready &&
                    (s_axi_araddr == `ARCT_ADDR_IRQ_STAT);

    // Per-mode actions
    // Capture modes share the top mode bit
    wire is_cap  = mode[1];
    wire do_cap  = is_cap && ext_evt;
    // Baud mode reloads on wrap only, never on an edge
    wire do_rld  = !is_cap && (wrap ||
                   (mode == `ARCT_MODE_RELOAD && ext_evt));
    // Baud wraps never raise the overflow flag
    wire set_ovf = wrap && (mode != `ARCT_MODE_BAUD);
    wire set_exf = ext_evt;

    ////////////////////////////////////////////////////////////////////
    // Control register; hardware set wins over software clear
    // Writing one keeps a flag, writing zero clears it
    always @(posedge clk_sys) begin
        if (reset) begin
            ctrl_q   <= `ARCT_RST_BYTE;
            capsrc_q <= 2'b00;
            mask_q   <= 2'b00;
            ien_q    <= 1'b0;
        end else begin
            if (wr_ctrl)
                ctrl_q[5:0] <= wbyte[5:0];
            ctrl_q[`ARCT_BIT_OVF] <= set_ovf | (wr_ctrl ?
                wbyte[`ARCT_BIT_OVF] & ctrl_q[`ARCT_BIT_OVF] :
                ctrl_q[`ARCT_BIT_OVF]);
            ctrl_q[`ARCT_BIT_EXF] <= set_exf | (wr_ctrl ?
                wbyte[`ARCT_BIT_EXF] & ctrl_q[`ARCT_BIT_EXF] :
                ctrl_q[`ARCT_BIT_EXF]);
            if (wr_en && aw_q == `ARCT_ADDR_CAPSRC)
                capsrc_q <= wbyte[1:0];
            if (wr_en && aw_q == `ARCT_ADDR_IRQ_MASK)
                mask_q <= wbyte[1:0];
            if (wr_en && aw_q == `ARCT_ADDR_IEN)
                ien_q <= wbyte[0];
        end
    end

    // Sticky status, cleared by read; set wins
    // Status bits mirror flag events for the mask path
    always @(posedge clk_sys) begin
        if (reset)
            stat_q <= 2'b00;
        else
            stat_q <= {set_ovf, set_exf} | (rd_stat ? 2'b00 : stat_q);
    end

    // Counter and reload/capture pair
    // Reload or tick beats a software byte write
    always @(posedge clk_sys) begin
        if (reset) begin
            cnt_q  <= `ARCT_CNT_ZERO;
            rcap_q <= `ARCT_CNT_ZERO;
        end else begin
            // Capture first, then software
            if (do_cap)
                rcap_q <= cnt_q;
            else if (wr_rc_l)
                rcap_q[7:0] <= wbyte;
            else if (wr_rc_h)
                rcap_q[15:8] <= wbyte;
            // Reload first, then tick, then software
            if (do_rld)
                cnt_q <= rcap_q;
            else if (tick)
                cnt_q <= cnt_q + 16'h0001;
            else if (wr_cnt_l)
                cnt_q[7:0] <= wbyte;
            else if (wr_cnt_h)
                cnt_q[15:8] <= wbyte;
        end
    end

    // Baud oversample divider, one tick per sixteen wraps
    // Oversampler moves only on baud-mode wraps
    always @(posedge clk_sys) begin
        if (reset) begin
            ovs_q     <= 4'h0;
            baud_tick <= 1'b0;
        end else begin
            baud_tick <= 1'b0;
            if (wrap && mode == `ARCT_MODE_BAUD) begin
                ovs_q <= ovs_q + 4'h1;
                if (ovs_q == `ARCT_BAUD_OVS)
                    baud_tick <= 1'b1;
            end
        end
    end

    // Interrupt: enable gate on control flags
    wire irq_flag = ien_q & (ctrl_q[`ARCT_BIT_OVF] |
                             ctrl_q[`ARCT_BIT_EXF]);
    // Mask gate on sticky status
    wire irq_stat = |(stat_q & mask_q);
    assign irq = irq_flag | irq_stat;

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channels
    // Refuse a new half while a response is pending
    assign s_axi_awready = !awf_q && !s_axi_bvalid;
    assign s_axi_wready  = !wf_q && !s_axi_bvalid;

    // Hold each half until both are in, then answer
    always @(posedge clk_sys) begin
        if (reset) begin
            awf_q        <= 1'b0;
            wf_q         <= 1'b0;
            aw_q         <= 8'h00;
            wd_q         <= 32'h0000_0000;
            ws_q         <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ARCT_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !awf_q) begin
                awf_q <= 1'b1;
                aw_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !wf_q) begin
                wf_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                awf_q        <= 1'b0;
                wf_q         <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_bad ? `ARCT_RESP_SLVERR
                                       : `ARCT_RESP_OKAY;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // AXI4-Lite read channels
    assign s_axi_arready = !s_axi_rvalid;
    // Read data mux on the request address
    reg [7:0] rmux;
    reg       rbad;
    always @* begin
        rbad = 1'b0;
        case (s_axi_araddr)
            `ARCT_ADDR_CTRL:     rmux = ctrl_q;
            `ARCT_ADDR_CAPSRC:   rmux = {6'b000000, capsrc_q};
            `ARCT_ADDR_CNT_LO:   rmux = cnt_q[7:0];
            `ARCT_ADDR_CNT_HI:   rmux = cnt_q[15:8];
            `ARCT_ADDR_RCAP_LO:  rmux = rcap_q[7:0];
            `ARCT_ADDR_RCAP_HI:  rmux = rcap_q[15:8];
            `ARCT_ADDR_IRQ_STAT: rmux = {6'b000000, stat_q};
            `ARCT_ADDR_IRQ_MASK: rmux = {6'b000000, mask_q};
            `ARCT_ADDR_IEN:      rmux = {7'b0000000, ien_q};
            default: begin
                rmux = 8'h00;
                rbad = 1'b1;
            end
        endcase
    end

    // Read answer, held until taken
    always @(posedge clk_sys) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `ARCT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rmux};
            s_axi_rresp  <= rbad ? `ARCT_RESP_SLVERR : `ARCT_RESP_OKAY;
        end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule // arct_timer
`default_nettype wire

// ### sim/arct_timer_assertions.sv
`include "arct_defs.vh"
`default_nettype none
module arct_timer_checker (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        baud_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Bus handshake steps
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read not answered");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid)
        else $error("write answer held too long");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid)
        else $error("read answer held too long");
    a_busy_refuses: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_read_refuses: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_unmapped_err: assert property (rd_taken ##0 s_axi_araddr > 8'h20 |=>
        s_axi_rresp == `ARCT_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_rdata_upper: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    a_baud_spacing: assert property (baud_tick |=> (!baud_tick) [*8])
        else $error("baud pulses too close");
endmodule // arct_timer_checker
bind arct_timer arct_timer_checker u_chk (.*);
`default_nettype wire

// ### sim/arct_src_model.sv
`default_nettype none
module arct_src_model (
    input  wire logic       clk_sys,
    input  wire logic       fire,
    input  wire logic [1:0] sel,
    output logic      [3:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] len_q = 3'h0;
    // Four-cycle pulse on the chosen source, sources stay low between
    always @(posedge clk_sys) begin
        if (fire)
            len_q <= 3'h4;
        else if (len_q != 3'h0)
            len_q <= len_q - 3'h1;
    end
    // Pulse wider than two cycles for the synchroniser
    assign pins = (len_q != 3'h0) ? (4'h1 << sel) : 4'h0;
endmodule // arct_src_model
`default_nettype wire

// ### sim/arct_timer_tb.sv
`include "arct_defs.vh"
`default_nettype none
module arct_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 0, reset = 1, fire = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, rv;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic        s_axi_bready = 1, s_axi_rready = 1;
    logic [1:0]  sel = 0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic   s_axi_rvalid, baud_tick, irq;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [3:0]  pins;
    wire logic   trigger_input_pin = pins[0], lf_rc_clock = pins[1];
    wire logic   uart_one_receive_pin = pins[2];
    wire logic   uart_two_receive_pin = pins[3];
    logic [33:0] exp_q[$];
    int          error_cnt = 0, cmp_count = 0, seed = 32'hd632, n;

    arct_timer DUT (.*);
    arct_src_model u_src (.clk_sys(clk_sys), .fire(fire), .sel(sel),
                          .pins(pins));

    // System clock
    always #50 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task results;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic logic [33:0] ok(input logic [7:0] d);
        return {`ARCT_RESP_OKAY, 24'h00_0000, d};
    endfunction
    task cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
    endtask
    task rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
    endtask
    task pulse(input logic [1:0] s);
        sel <= s;
        fire <= 1;
        @(posedge clk_sys);
        fire <= 0;
        cyc(12);
    endtask

    // Read watcher: oldest note against each answer
    always @(posedge clk_sys) begin
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        results;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(20);
        reset <= 0;
        cyc(1);
        for (n = 0; n < 6; n++) rd(8'(n * 4), ok(8'h00));
        rd(8'h24, {`ARCT_RESP_SLVERR, 32'h0000_0000});
        // Auto-reload wrap
        wr(`ARCT_ADDR_IEN, 8'h01);
        wr(`ARCT_ADDR_RCAP_LO, 8'hF0);
        wr(`ARCT_ADDR_RCAP_HI, 8'hFF);
        wr(`ARCT_ADDR_CNT_LO, 8'hFE);
        wr(`ARCT_ADDR_CNT_HI, 8'hFF);
        wr(`ARCT_ADDR_CTRL, 8'h02);
        cyc(40);
        chk(irq, 1);
        rd(`ARCT_ADDR_CTRL, ok(8'h82));
        wr(`ARCT_ADDR_CTRL, 8'h80);
        rd(`ARCT_ADDR_CTRL, ok(8'h80));
        rd(`ARCT_ADDR_CNT_HI, ok(8'hFF));
        rd(`ARCT_ADDR_IRQ_STAT, ok(8'h02));
        wr(`ARCT_ADDR_CTRL, 8'h00);
        cyc(1);
        chk(irq, 0);
        // Baud generator period and extra event source
        wr(`ARCT_ADDR_RCAP_LO, 8'hFE);
        wr(`ARCT_ADDR_CNT_LO, 8'hFE);
        wr(`ARCT_ADDR_CTRL, 8'h06);
        do @(posedge clk_sys); while (!baud_tick);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!baud_tick);
        chk(34'(n), 34'(16 * (65536 - 32'h0000_FFFE)));
        wr(`ARCT_ADDR_CTRL, 8'h07);
        pulse(2'h0);
        rd(`ARCT_ADDR_CTRL, ok(8'h47));
        rd(`ARCT_ADDR_IRQ_STAT, ok(8'h01));
        wr(`ARCT_ADDR_CTRL, 8'h00);
        wr(`ARCT_ADDR_IRQ_MASK, 8'h01);
        wr(`ARCT_ADDR_IEN, 8'h00);
        // Trigger ignored while the enable is clear
        wr(`ARCT_ADDR_CTRL, 8'h3A);
        pulse(2'h0);
        rd(`ARCT_ADDR_CTRL, ok(8'h3A));
        wr(`ARCT_ADDR_CTRL, 8'h00);
        // Edge reload in reload mode with the enable set
        wr(`ARCT_ADDR_RCAP_LO, 8'h34);
        wr(`ARCT_ADDR_RCAP_HI, 8'h12);
        wr(`ARCT_ADDR_CTRL, 8'h33);
        pulse(2'h0);
        rd(`ARCT_ADDR_CNT_LO, ok(8'h34));
        rd(`ARCT_ADDR_CNT_HI, ok(8'h12));
        rd(`ARCT_ADDR_CTRL, ok(8'h73));
        rd(`ARCT_ADDR_IRQ_STAT, ok(8'h01));
        wr(`ARCT_ADDR_CTRL, 8'h00);
        // Capture from each source, rising and falling in turn
        for (n = 0; n < 4; n++) begin
            rv = 8'($random(seed));
            wr(`ARCT_ADDR_CNT_LO, rv);
            wr(`ARCT_ADDR_CNT_HI, 8'(n));
            wr(`ARCT_ADDR_CAPSRC, 8'(n));
            wr(`ARCT_ADDR_CTRL, n[0] ? 8'h3F : 8'h3B);
            pulse(2'(n));
            chk(irq, 1);
            rd(`ARCT_ADDR_RCAP_LO, ok(rv));
            rd(`ARCT_ADDR_RCAP_HI, ok(8'(n)));
            rd(`ARCT_ADDR_CTRL, ok(n[0] ? 8'h7F : 8'h7B));
            rd(`ARCT_ADDR_IRQ_STAT, ok(8'h01));
            cyc(1);
            chk(irq, 0);
            wr(`ARCT_ADDR_CTRL, 8'h00);
        end
        results;
    end
endmodule // arct_timer_tb
`default_nettype wire
